// ---- verilog/channel_divider_pkg.sv ----
/*
 Constants of the cascaded two-stage channel clock divider: register
 indices, byte addresses, field positions, reset values.
 Assumes a 32-bit APB slave with 12-bit byte addresses.
*/
// Function
// - Stage one stays low for low-count plus one input cycles, reset zero.
// - Stage one stays high for high-count plus one input cycles, reset zero.
// - Stage two stays low for its low-count plus one input cycles.
// - Stage two stays high for its high-count plus one input cycles.
// - Per-stage four-bit phase offsets, stage two upper nibble, reset zero.
// - Stage two bypass powers down its counter and passes its input.
// - Stage one bypass powers down its counter and passes its input.
// - Sync-ignore bit clear obeys chip sync; set ignores it.
// - Force bit drives channel output high; needs sync-ignore also set.
// - Stage two begins high when its start bit is one, else low.
// - Stage one begins high when its start bit is one, else low.
// - Duty correction active while its disable bit is zero.
package channel_divider_pkg;
	localparam logic [9:0] IDX_STAGE_ONE_CYCLE_COUNTS = 10'h199;
	localparam logic [9:0] IDX_STAGE_PHASE_OFFSETS = 10'h19A;
	localparam logic [9:0] IDX_STAGE_TWO_CYCLE_COUNTS = 10'h19B;
	localparam logic [9:0] IDX_CHANNEL_DIVIDER_CONTROL = 10'h19C;
	localparam logic [9:0] IDX_CHANNEL_DUTY_CORRECTION = 10'h19D;
	localparam logic [9:0] IDX_CHANNEL_STATUS = 10'h1F0;
	localparam logic [11:0] ADDR_STAGE_ONE_CYCLE_COUNTS = {IDX_STAGE_ONE_CYCLE_COUNTS, 2'h0};
	localparam logic [11:0] ADDR_STAGE_PHASE_OFFSETS = {IDX_STAGE_PHASE_OFFSETS, 2'h0};
	localparam logic [11:0] ADDR_STAGE_TWO_CYCLE_COUNTS = {IDX_STAGE_TWO_CYCLE_COUNTS, 2'h0};
	localparam logic [11:0] ADDR_CHANNEL_DIVIDER_CONTROL = {IDX_CHANNEL_DIVIDER_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_CHANNEL_DUTY_CORRECTION = {IDX_CHANNEL_DUTY_CORRECTION, 2'h0};
	localparam logic [11:0] ADDR_CHANNEL_STATUS = {IDX_CHANNEL_STATUS, 2'h0};
	localparam int LOW_COUNT_LSB = 4;
	localparam int HIGH_COUNT_LSB = 0;
	localparam int STAGE_TWO_PHASE_LSB = 4;
	localparam int STAGE_ONE_PHASE_LSB = 0;
	localparam int BYPASS_TWO_BIT = 5;
	localparam int BYPASS_ONE_BIT = 4;
	localparam int SYNC_IGNORE_BIT = 3;
	localparam int FORCE_BIT = 2;
	localparam int START_TWO_BIT = 1;
	localparam int START_ONE_BIT = 0;
	localparam int DUTY_DISABLE_BIT = 0;
	localparam int STATUS_LEVEL_ONE_BIT = 0;
	localparam int STATUS_LEVEL_TWO_BIT = 1;
	localparam int STATUS_SYNC_HOLD_BIT = 2;
	localparam int STATUS_CHANNEL_BIT = 3;
	localparam logic [7:0] COUNTS_RESET = 8'h00;
	localparam logic [7:0] PHASE_RESET = 8'h00;
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic DUTY_RESET = 1'b0;
endpackage

// ---- verilog/cascaded_clock_channel_divider.sv ----
/*
 Cascaded two-stage channel clock divider with APB register access.
 Assumes div_in_en is a one-cycle pulse per divider input clock cycle
 on pclk; sync_n is an asynchronous active-low chip-level sync pin.
*/
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module cascaded_clock_channel_divider (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic div_in_en,
	input wire logic sync_n,
	output logic stage_one_out,
	output logic stage_two_out,
	output logic channel_out,
	output logic channel_tick,
	output logic duty_correction_enable
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] one_counts;
		logic [7:0] phase_offsets;
		logic [7:0] two_counts;
		logic [5:0] control;
		logic duty_disable;
		logic sync_meta;
		logic sync_n_q;
		logic [1:0] level;
		logic [1:0] tick;
		logic [1:0] phasing;
		logic [1:0][3:0] cnt;
		logic [1:0][3:0] phase;
		logic chan_out;
		logic duty_en;
		logic [31:0] rdata;
		logic err;
	} state_s;

	state_s s;
	state_s next_s;
	logic hold;
	logic forced;
	logic [1:0] stage_in;
	logic [1:0] byp;
	logic [1:0] start;
	logic [1:0][3:0] lo;
	logic [1:0][3:0] hi;
	logic [1:0][3:0] off;
	logic mapped;
	logic [31:0] rd;

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.sync_meta = sync_n;
		next_s.sync_n_q = s.sync_meta;
		hold = !s.sync_n_q
			&& !s.control[channel_divider_pkg::SYNC_IGNORE_BIT];
		forced = s.control[channel_divider_pkg::SYNC_IGNORE_BIT]
			&& s.control[channel_divider_pkg::FORCE_BIT];
		stage_in[0] = div_in_en;
		stage_in[1] = s.tick[0];
		byp[0] = s.control[channel_divider_pkg::BYPASS_ONE_BIT];
		byp[1] = s.control[channel_divider_pkg::BYPASS_TWO_BIT];
		start[0] = s.control[channel_divider_pkg::START_ONE_BIT];
		start[1] = s.control[channel_divider_pkg::START_TWO_BIT];
		lo[0] = s.one_counts[channel_divider_pkg::LOW_COUNT_LSB +: 4];
		hi[0] = s.one_counts[channel_divider_pkg::HIGH_COUNT_LSB +: 4];
		lo[1] = s.two_counts[channel_divider_pkg::LOW_COUNT_LSB +: 4];
		hi[1] = s.two_counts[channel_divider_pkg::HIGH_COUNT_LSB +: 4];
		off[0] = s.phase_offsets[channel_divider_pkg::STAGE_ONE_PHASE_LSB +: 4];
		off[1] = s.phase_offsets[channel_divider_pkg::STAGE_TWO_PHASE_LSB +: 4];
		for (int i = 0; i < 2; i++) begin
			next_s.tick[i] = 1'b0;
			if (byp[i]) begin
				// Counter powered down, input passed through
				next_s.level[i] = stage_in[i];
				next_s.tick[i] = stage_in[i];
				next_s.cnt[i] = 4'h0;
				next_s.phase[i] = 4'h0;
				next_s.phasing[i] = 1'b0;
			end else if (hold) begin
				// Restart from start level and phase offset
				next_s.level[i] = start[i];
				next_s.cnt[i] = start[i] ? hi[i] : lo[i];
				next_s.phase[i] = off[i];
				next_s.phasing[i] = (off[i] != 4'h0);
			end else if (stage_in[i]) begin
				if (s.phasing[i]) begin
					next_s.phase[i] = s.phase[i] - 4'h1;
					next_s.phasing[i] = (s.phase[i] != 4'h1);
				end else if (s.cnt[i] == 4'h0) begin
					next_s.level[i] = !s.level[i];
					next_s.cnt[i] = s.level[i] ? lo[i] : hi[i];
					next_s.tick[i] = !s.level[i];
				end else begin
					next_s.cnt[i] = s.cnt[i] - 4'h1;
				end
			end
		end
		next_s.chan_out = forced ? 1'b1 : s.level[1];
		next_s.duty_en = !s.duty_disable;

		// APB decode
		mapped = 1'b1;
		rd = 32'h0000_0000;
		unique case (paddr)
			channel_divider_pkg::ADDR_STAGE_ONE_CYCLE_COUNTS: begin
				rd = {24'h00_0000, s.one_counts};
			end
			channel_divider_pkg::ADDR_STAGE_PHASE_OFFSETS: begin
				rd = {24'h00_0000, s.phase_offsets};
			end
			channel_divider_pkg::ADDR_STAGE_TWO_CYCLE_COUNTS: begin
				rd = {24'h00_0000, s.two_counts};
			end
			channel_divider_pkg::ADDR_CHANNEL_DIVIDER_CONTROL: begin
				rd = {26'h000_0000, s.control};
			end
			channel_divider_pkg::ADDR_CHANNEL_DUTY_CORRECTION: begin
				rd = {31'h0000_0000, s.duty_disable};
			end
			channel_divider_pkg::ADDR_CHANNEL_STATUS: begin
				rd[channel_divider_pkg::STATUS_LEVEL_ONE_BIT] = s.level[0];
				rd[channel_divider_pkg::STATUS_LEVEL_TWO_BIT] = s.level[1];
				rd[channel_divider_pkg::STATUS_SYNC_HOLD_BIT] = hold;
				rd[channel_divider_pkg::STATUS_CHANNEL_BIT] = s.chan_out;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (psel && !penable) begin
			next_s.rdata = (pwrite || !mapped) ? 32'h0000_0000 : rd;
			next_s.err = !mapped;
		end
		if (psel && penable && pwrite) begin
			unique case (paddr)
				channel_divider_pkg::ADDR_STAGE_ONE_CYCLE_COUNTS: begin
					next_s.one_counts = pwdata[7:0];
				end
				channel_divider_pkg::ADDR_STAGE_PHASE_OFFSETS: begin
					next_s.phase_offsets = pwdata[7:0];
				end
				channel_divider_pkg::ADDR_STAGE_TWO_CYCLE_COUNTS: begin
					next_s.two_counts = pwdata[7:0];
				end
				channel_divider_pkg::ADDR_CHANNEL_DIVIDER_CONTROL: begin
					next_s.control = pwdata[5:0];
				end
				channel_divider_pkg::ADDR_CHANNEL_DUTY_CORRECTION: begin
					next_s.duty_disable =
						pwdata[channel_divider_pkg::DUTY_DISABLE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.one_counts <= channel_divider_pkg::COUNTS_RESET;
			s.two_counts <= channel_divider_pkg::COUNTS_RESET;
			s.phase_offsets <= channel_divider_pkg::PHASE_RESET;
			s.control <= channel_divider_pkg::CONTROL_RESET;
			s.duty_disable <= channel_divider_pkg::DUTY_RESET;
			s.sync_meta <= 1'b1;
			s.sync_n_q <= 1'b1;
			s.duty_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && s.err;
	assign stage_one_out = s.level[0];
	assign stage_two_out = s.level[1];
	assign channel_out = s.chan_out;
	assign channel_tick = s.tick[1];
	assign duty_correction_enable = s.duty_en;

	// ==========================================================
	// Checks
	one_low_width_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(s.level[0]) && !$past(byp[0]) && !$past(hold)
		|-> s.cnt[0] == $past(lo[0]))
		else $error("Stage one low count wrong");
	one_high_width_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(s.level[0]) && !$past(byp[0]) && !$past(hold)
		|-> s.cnt[0] == $past(hi[0]))
		else $error("Stage one high count wrong");
	two_low_width_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(s.level[1]) && !$past(byp[1]) && !$past(hold)
		|-> s.cnt[1] == $past(lo[1]))
		else $error("Stage two low count wrong");
	two_high_width_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(s.level[1]) && !$past(byp[1]) && !$past(hold)
		|-> s.cnt[1] == $past(hi[1]))
		else $error("Stage two high count wrong");
	phase_load_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[1] |=> s.phase[1] == $past(off[1]))
		else $error("Phase offset not loaded");
	two_bypass_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		byp[1] |=> s.level[1] == $past(s.tick[0]) && s.cnt[1] == 4'h0)
		else $error("Stage two bypass wrong");
	one_bypass_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		byp[0] && div_in_en |=> s.level[0] && s.tick[0])
		else $error("Stage one bypass wrong");
	sync_ignore_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.control[channel_divider_pkg::SYNC_IGNORE_BIT] && !byp[0] && div_in_en
		&& !s.phasing[0] && s.cnt[0] == 4'h0 |=> $changed(s.level[0]))
		else $error("Ignored sync still holds");
	force_high_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		forced |=> channel_out)
		else $error("Forced output not high");
	two_start_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[1] |=> s.level[1] == $past(start[1]))
		else $error("Stage two start level wrong");
	one_start_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] |=> s.level[0] == $past(start[0]))
		else $error("Stage one start level wrong");
	duty_enable_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$changed(s.duty_disable)
		|=> duty_correction_enable == $past(!s.duty_disable))
		else $error("Duty correction enable wrong");
	cascade_tick_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.tick[0] && !$past(byp[0]) |-> $rose(s.level[0]))
		else $error("Stage one tick without rise");
	restart_phase_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] && off[0] != 4'h0 ##1 !hold |-> s.phasing[0])
		else $error("Restart skipped phase offset");
	sync_obey_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!s.sync_meta && !s.control[channel_divider_pkg::SYNC_IGNORE_BIT]
		##1 !s.control[channel_divider_pkg::SYNC_IGNORE_BIT] |-> hold)
		else $error("Obeyed sync not held");
	hold_no_tick_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] |=> !s.tick[0])
		else $error("Tick during sync hold");
	one_restart_high_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] && start[0] |=> s.cnt[0] == $past(hi[0]))
		else $error("Stage one high restart count wrong");
	one_restart_low_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] && !start[0] |=> s.cnt[0] == $past(lo[0]))
		else $error("Stage one low restart count wrong");
	two_restart_high_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[1] && start[1] |=> s.cnt[1] == $past(hi[1]))
		else $error("Stage two high restart count wrong");
	one_phase_load_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hold && !byp[0] |=> s.phase[0] == $past(off[0]))
		else $error("Stage one phase offset not loaded");
	chan_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!forced |=> channel_out == $past(s.level[1]))
		else $error("Channel output not following stage two");
	duty_off_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.duty_disable |=> !duty_correction_enable)
		else $error("Duty correction not disabled");
	two_tick_rise_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.tick[1] && !$past(byp[1]) |-> $rose(s.level[1]))
		else $error("Stage two tick without rise");
	one_phase_still_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		s.phasing[0] && !hold && !byp[0] |=> s.level[0] == $past(s.level[0]))
		else $error("Stage one moved during phase offset");
	two_bypass_tick_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		byp[1] |=> s.tick[1] == $past(s.tick[0]))
		else $error("Stage two bypass tick wrong");
	one_bypass_idle_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		byp[0] && !div_in_en |=> !s.level[0] && !s.tick[0])
		else $error("Stage one bypass idle wrong");
	one_count_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!byp[0] && !hold && !s.phasing[0] && s.cnt[0] != 4'h0
		|=> s.level[0] == $past(s.level[0]))
		else $error("Stage one toggled before count end");
	two_count_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!byp[1] && !hold && !s.phasing[1] && s.cnt[1] != 4'h0
		|=> s.level[1] == $past(s.level[1]))
		else $error("Stage two toggled before count end");
	offsets_write_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pwrite
		&& paddr == channel_divider_pkg::ADDR_STAGE_PHASE_OFFSETS
		|=> s.phase_offsets == $past(pwdata[7:0]))
		else $error("Phase offset write lost");
	sync_phase_c: cover property (@(posedge pclk) disable iff (!presetn)
		s.phasing[0] ##1 !s.phasing[0]);
	cascade_run_c: cover property (@(posedge pclk) disable iff (!presetn)
		!byp[1] && !byp[0] && $rose(s.level[1]));
	sync_restart_c: cover property (@(posedge pclk) disable iff (!presetn)
		hold ##1 !hold);
	forced_out_c: cover property (@(posedge pclk) disable iff (!presetn)
		forced ##1 channel_out);
	bypass_pass_c: cover property (@(posedge pclk) disable iff (!presetn)
		byp[0] && byp[1] && div_in_en);
endmodule
`default_nettype wire

// ---- bench/clock_feed.sv ----
/*
 Divider input side: one div_in_en pulse every gap+1 clocks.
 Assumes the bench sets gap between tests.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_feed (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] gap,
	output logic div_in_en
);
	logic [1:0] cnt;
	// ============================================
	// Tick pacing, fast when gap is zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			div_in_en <= 1'b0;
		end else if (cnt >= gap) begin
			cnt <= 2'h0;
			div_in_en <= 1'b1;
		end else begin
			cnt <= cnt + 2'h1;
			div_in_en <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_cascaded_clock_channel_divider.sv ----
/*
 Bench of the channel divider: APB tasks and level run checks.
 Assumes the design package and the clock_feed partner.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cascaded_clock_channel_divider;
	localparam logic [11:0] B = channel_divider_pkg::ADDR_STAGE_ONE_CYCLE_COUNTS;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic sync_n = 1, pready, pslverr, div_in_en, err, cap_err;
	logic stage_one_out, stage_two_out, channel_out, channel_tick;
	logic duty_correction_enable;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, cap_rd;
	logic [1:0] gap = 0;
	int fail_count = 0, compares = 0, h, l, t0, k;
	// ============================================
	// Clock, capture, instances
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cap_rd <= prdata;
		cap_err <= pslverr;
	end
	cascaded_clock_channel_divider u_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .div_in_en,
		.sync_n, .stage_one_out, .stage_two_out, .channel_out, .channel_tick,
		.duty_correction_enable);
	clock_feed u_feed (.pclk, .presetn, .gap, .div_in_en);
	// ============================================
	// Tasks
	task automatic check(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		#1 rd = cap_rd;
		err = cap_err;
	endtask
	function automatic logic lvl(input int w);
		return w == 0 ? stage_one_out : (w == 1 ? stage_two_out : channel_out);
	endfunction
	task automatic runs(input int w);
		int n;
		n = 0;
		h = 0;
		l = 0;
		while (lvl(w) !== 1'b0 && n < 99) begin @(negedge pclk); n++; end
		while (lvl(w) !== 1'b1 && n < 99) begin @(negedge pclk); n++; end
		while (lvl(w) === 1'b1 && n < 99) begin @(negedge pclk); n++; h++; end
		while (lvl(w) === 1'b0 && n < 99) begin @(negedge pclk); n++; l++; end
	endtask
	task automatic chg(input int w);
		logic p;
		repeat (2) @(negedge pclk);
		p = lvl(w);
		t0 = 0;
		repeat (16) begin @(negedge pclk); t0 += (lvl(w) !== p); p = lvl(w); end
	endtask
	task automatic sync_set(input logic v);
		@(posedge pclk);
		sync_n <= v;
		t0 = 0;
		repeat (6) @(negedge pclk);
	endtask
	task automatic release_sync();
		@(posedge pclk);
		sync_n <= 1'b1;
		t0 = 0;
		do begin @(negedge pclk); t0++; end while (stage_one_out !== 1'b0 && t0 < 99);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ============================================
	// Tests
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			xfer(B + 12'(4 * i), 1'b0, 0);
			check("reset value", rd, 0);
		end
		check("duty enable", duty_correction_enable, 1);
		xfer(12'h000, 1'b0, 0);
		check("unmapped error", err, 1);
		wr_rd(B, 32'hFFFF_FFA5, 32'h0000_00A5);
		wr_rd(B + 12'h00C, 32'h0000_00FF, 32'h0000_003F);
		wr_rd(B + 12'h010, 32'h0000_0001, 32'h0000_0001);
		check("duty enable", duty_correction_enable, 0);
		xfer(B + 12'h00C, 1'b1, 0);
		xfer(B, 1'b1, 32'h0000_0021);
		runs(0);
		runs(0);
		check("one high", h, 2);
		check("one low", l, 3);
		gap <= 2'h1;
		runs(0);
		runs(0);
		check("one high slow", h, 4);
		check("one low slow", l, 6);
		gap <= 2'h0;
		xfer(B, 1'b1, 0);
		xfer(B + 12'h008, 1'b1, 32'h0000_0010);
		runs(1);
		runs(1);
		check("two high", h, 2);
		check("two low", l, 4);
		k = 0;
		repeat (12) begin @(negedge pclk); k += channel_tick; end
		check("tick count", k, 2);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0010);
		gap <= 2'h1;
		runs(0);
		runs(0);
		check("bypass one", {h[7:0], l[7:0]}, 32'h0000_0101);
		gap <= 2'h0;
		xfer(B, 1'b1, 32'h0000_0011);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0020);
		runs(1);
		runs(1);
		check("bypass two", {h[7:0], l[7:0]}, 32'h0000_0103);
		xfer(B, 1'b1, 0);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0001);
		sync_set(1'b0);
		check("start one", stage_one_out, 1);
		check("start two", stage_two_out, 0);
		release_sync();
		l = t0;
		xfer(B + 12'h004, 1'b1, 32'h0000_0003);
		sync_set(1'b0);
		release_sync();
		check("offset delay", t0 - l, 3);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0003);
		sync_set(1'b0);
		check("start two high", stage_two_out, 1);
		xfer(channel_divider_pkg::ADDR_CHANNEL_STATUS, 1'b0, 0);
		check("status", rd, 32'h0000_000F);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0008);
		chg(0);
		check("sync ignored", t0 != 0, 1);
		xfer(B + 12'h00C, 1'b1, 32'h0000_000C);
		chg(2);
		check("forced steady", t0, 0);
		check("forced high", channel_out, 1);
		sync_set(1'b1);
		xfer(B + 12'h00C, 1'b1, 32'h0000_0004);
		chg(2);
		check("force needs ignore", t0 != 0, 1);
		complete_run();
	end
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, e);
		xfer(a, 1'b1, d);
		xfer(a, 1'b0, 0);
		check("readback", rd, e);
	endtask
endmodule
`default_nettype wire
